// ==== rtl/mcc_top.sv ====
// Contract
// - monitoring-result output active while object sits in the active field
// - reset-needed output flashes when interlock latched and field clear again
// - static control inputs select the active monitoring case
// - reset pushbutton clears the restart interlock
// - pushbuttons for sleep, complete restart and pausing event history
// - immediate mode: safe pair on as soon as protective field clear
// - interlocked mode: safe pair stays off after stop until reset
// - automatic mode: safe pair on after configured delay of clear field
// - feedback checking: feedback input must be energised after switch-off
// - missing feedback after switch-off enters locking, pair stays off
// - each non-safe output selectable active-high or active-low; only uout has pol, sleep_active, event_pause and locking are fixed
// - antivalent channels must stay inverted; else all safe outputs off, error
// - new input combination evaluated only after the input delay
// - case active only for exactly its assigned input combination
// - case with sleep option enters sleep mode at once
// - each cut-off path drives its outputs from its mapped field
// - forced-off path holds all its outputs off
// - forced-on-unsafe path: safety outputs off, non-safety outputs on
// - forced-on-safe path behaves as a permanently clear field
// - path with no field assigned defaults to forced-off
// - device error switches safe outputs off and locks until restart
`timescale 1ns/100ps
`include "mcc_defs.svh"

module mcc_top #(
  parameter int CYC_PER_MS = `MCC_MS_NS / `MCC_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // static control inputs, two channels
  input  wire logic [1:0]  ctl_a,
  input  wire logic [1:0]  ctl_b,
  // scanner results and feedback
  input  wire logic [1:0]  field_obj,
  input  wire logic        contactor_fb,
  input  wire logic        dev_err,
  // pushbuttons
  input  wire logic        btn_reset,
  input  wire logic        btn_sleep,
  input  wire logic        btn_restart,
  input  wire logic        btn_pause,
  // machine side outputs
  output logic             safe_output_pair_a,
  output logic             safe_output_pair_b,
  output logic [3:0]       uout,
  output logic             sleep_active,
  output logic             event_pause,
  output logic             locking
);

  // ----------------------------------------------------------------------
  // state and cut-off paths
  // ----------------------------------------------------------------------
  mcc_pkg::mcc_state_t s_q;
  mcc_pkg::mcc_state_t s_d;
  logic [5:0]          cfg;
  logic                live;

  mcc_path_if pif[2] ();

  // a case without the used bit counts as unassigned
  assign cfg  = s_q.case_cfg[s_q.act_case];
  assign live = s_q.case_ok && cfg[`MCC_CASE_USED];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_path
      // unassigned paths fall back to forced-off
      assign pif[gi].beh = live ?
        mcc_pkg::mcc_beh_t'(cfg[2*gi +: 2]) : mcc_pkg::MCC_BEH_OFF;
      assign pif[gi].field_obj = field_obj[gi];
      mcc_cutoff_path u_path (
        .p (pif[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] wmerge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [3:0]  bt;
    logic        tick;
    logic        anti_bad;
    logic        clear;
    logic        permit;
    logic [31:0] cur;
    logic [31:0] stat;
    logic [3:0]  sig;
    bt       = 4'h0;
    tick     = 1'b0;
    anti_bad = 1'b0;
    clear    = 1'b0;
    permit   = 1'b0;
    cur      = 32'h0;
    stat     = 32'h0;
    sig      = 4'h0;
    s_d      = s_q;

    // millisecond time base for all delays
    tick = (s_q.ms_cnt == 18'(CYC_PER_MS - 1));
    s_d.ms_cnt = tick ? 18'h0 : s_q.ms_cnt + 18'h1;

    // pushbutton rising edges: reset, sleep, restart, pause
    bt = {btn_pause, btn_restart, btn_sleep, btn_reset} & ~s_q.btn_prev;
    s_d.btn_prev = {btn_pause, btn_restart, btn_sleep, btn_reset};

    // status word
    stat = {22'h0, s_q.ev_pause, s_q.cfb_fault, s_q.sleep, s_q.anti_err,
            s_q.locking, s_q.latch, s_q.on, s_q.case_ok, s_q.act_case};

    // write channel: address and data taken in either order
    if (s_q.awready && awvalid) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = awaddr[7:0];
    end
    if (s_q.wready && wvalid) begin
      s_d.w_have = 1'b1;
      s_d.wdata  = wdata;
      s_d.wstrb  = wstrb;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = `MCC_RESP_OKAY;
      case (s_q.aw_addr & 8'hFC)
        `MCC_OFF_CTRL: begin
          cur = {24'h0, s_q.pol, s_q.anti_en, s_q.cfb_en, s_q.rs_mode};
          cur = wmerge(cur, s_q.wdata, s_q.wstrb);
          s_d.rs_mode = cur[`MCC_CTRL_MODE_LSB +: 2];
          s_d.cfb_en  = cur[`MCC_CTRL_CFB];
          s_d.anti_en = cur[`MCC_CTRL_ANTI];
          s_d.pol     = cur[`MCC_CTRL_POL_LSB +: 4];
        end
        `MCC_OFF_IN_DLY: begin
          cur = wmerge({16'h0, s_q.in_dly_ms}, s_q.wdata, s_q.wstrb);
          s_d.in_dly_ms = cur[15:0];
        end
        `MCC_OFF_AUTO_DLY: begin
          cur = wmerge({16'h0, s_q.auto_dly_ms}, s_q.wdata, s_q.wstrb);
          s_d.auto_dly_ms = cur[15:0];
        end
        `MCC_OFF_STATUS: begin
          s_d.bresp = `MCC_RESP_OKAY; // read-only, write ignored
        end
        default: begin
          if (s_q.aw_addr >= `MCC_OFF_CASE0 && s_q.aw_addr <= `MCC_OFF_CASE3 + 8'h3) begin
            cur = wmerge({26'h0, s_q.case_cfg[s_q.aw_addr[3:2]]}, s_q.wdata, s_q.wstrb);
            s_d.case_cfg[s_q.aw_addr[3:2]] = cur[5:0];
          end else begin
            s_d.bresp = `MCC_RESP_SLVERR;
          end
        end
      endcase
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready  = !s_d.w_have && !s_d.bvalid;

    // read channel: one cycle from address to data
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_q.arready && arvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = `MCC_RESP_OKAY;
      case (araddr[7:0] & 8'hFC)
        `MCC_OFF_CTRL: begin
          s_d.rdata = {24'h0, s_q.pol, s_q.anti_en, s_q.cfb_en, s_q.rs_mode};
        end
        `MCC_OFF_IN_DLY:   s_d.rdata = {16'h0, s_q.in_dly_ms};
        `MCC_OFF_AUTO_DLY: s_d.rdata = {16'h0, s_q.auto_dly_ms};
        `MCC_OFF_STATUS:   s_d.rdata = stat;
        default: begin
          if (araddr[7:0] >= `MCC_OFF_CASE0 && araddr[7:0] <= `MCC_OFF_CASE3 + 8'h3) begin
            s_d.rdata = {26'h0, s_q.case_cfg[araddr[3:2]]};
          end else begin
            s_d.rdata = 32'h0;
            s_d.rresp = `MCC_RESP_SLVERR;
          end
        end
      endcase
    end
    s_d.arready = !s_d.rvalid;

    // antivalence check: second channel must be the bitwise inverse of the first
    anti_bad = s_q.anti_en && (ctl_b != ~ctl_a);
    s_d.anti_err = anti_bad;

    // debounce: a combination must hold for the input delay
    if (ctl_a != s_q.cand) begin
      s_d.cand    = ctl_a;
      s_d.dly_cnt = 16'h0;
    end else if (s_q.dly_cnt >= s_q.in_dly_ms) begin
      if (!anti_bad) begin
        s_d.act_case = s_q.cand;
        s_d.case_ok  = 1'b1;
      end
    end else if (tick) begin
      s_d.dly_cnt = s_q.dly_cnt + 16'h1;
    end

    // path 0 is the protective field feeding the safe output pair
    clear = pif[0].safe_on;

    // sleep: pushbutton latch or case option, reset button clears the pushbutton latch
    if (bt[1]) begin
      s_d.sleep_btn = 1'b1;
    end else if (bt[0]) begin
      s_d.sleep_btn = 1'b0;
    end
    s_d.sleep = s_d.sleep_btn || (live && cfg[`MCC_CASE_SLEEP]);

    // restart behaviour of the safe output pair
    case (mcc_pkg::mcc_restart_t'(s_q.rs_mode))
      mcc_pkg::MCC_RS_IMMEDIATE: begin
        s_d.latch = 1'b0;
        permit    = clear;
      end
      mcc_pkg::MCC_RS_AUTO: begin
        s_d.latch = 1'b0;
        if (!clear) begin
          s_d.auto_cnt = s_q.auto_dly_ms;
        end else if (tick && s_q.auto_cnt != 16'h0) begin
          s_d.auto_cnt = s_q.auto_cnt - 16'h1;
        end
        permit = clear && (s_q.auto_cnt == 16'h0);
      end
      default: begin
        // a new stop wins over a reset press in the same cycle
        if (!clear) begin
          s_d.latch = 1'b1;
        end else if (bt[0]) begin
          s_d.latch = 1'b0;
        end
        permit = clear && !s_q.latch;
      end
    endcase

    // complete restart clears safety state, keeps config; a same-cycle fault still wins
    if (bt[2]) begin
      s_d.latch     = 1'b0;
      s_d.locking   = 1'b0;
      s_d.cfb_fault = 1'b0;
      s_d.cfb_wait  = 1'b0;
      s_d.case_ok   = 1'b0;
      s_d.dly_cnt   = 16'h0;
      s_d.sleep_btn = 1'b0;
      s_d.sleep     = 1'b0;
    end

    // contactor feedback window opened when permit drops while the pair is on and no window is running
    if (s_q.on && !s_q.cfb_wait && !permit) begin
      s_d.cfb_wait = 1'b1;
      s_d.cfb_cnt  = 16'h0;
    end else if (s_q.cfb_wait) begin
      if (s_q.cfb_cnt >= `MCC_CFB_WAIT_MS) begin
        s_d.cfb_wait = 1'b0;
        if (s_q.cfb_en && !contactor_fb) begin
          s_d.cfb_fault = 1'b1;
          s_d.locking   = 1'b1;
        end
      end else if (tick) begin
        s_d.cfb_cnt = s_q.cfb_cnt + 16'h1;
      end
    end

    // a live device error always wins over the restart
    if (dev_err) begin
      s_d.locking = 1'b1;
    end

    // safe pair only on with nothing holding it off
    s_d.on = permit && !s_d.locking && !s_q.locking && !anti_bad && !s_d.sleep;

    // event history pause toggles per press
    if (bt[3]) begin
      s_d.ev_pause = !s_q.ev_pause;
    end

    // flash rate for the reset-needed lamp
    if (tick) begin
      if (s_q.blink_cnt >= `MCC_BLINK_HALF_MS - 10'h1) begin
        s_d.blink_cnt = 10'h0;
        s_d.blink     = !s_q.blink;
      end else begin
        s_d.blink_cnt = s_q.blink_cnt + 10'h1;
      end
    end

    // universal outputs: warning path, result, reset needed, error
    sig[0] = pif[1].nonsafe_on;
    sig[1] = live && (pif[0].beh == mcc_pkg::MCC_BEH_FIELD) && field_obj[0];
    sig[2] = s_q.latch && clear && s_q.blink;
    sig[3] = s_q.locking || s_q.anti_err || s_q.cfb_fault;
    s_d.uout = sig ^ s_q.pol;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q             <= '0;
      s_q.in_dly_ms   <= `MCC_IN_DELAY_MS;
      s_q.auto_dly_ms <= `MCC_AUTO_DELAY_MS;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign awready            = s_q.awready;
  assign wready             = s_q.wready;
  assign bvalid             = s_q.bvalid;
  assign bresp              = s_q.bresp;
  assign arready            = s_q.arready;
  assign rvalid             = s_q.rvalid;
  assign rdata              = s_q.rdata;
  assign rresp              = s_q.rresp;
  assign safe_output_pair_a = s_q.on;
  assign safe_output_pair_b = s_q.on;
  assign uout               = s_q.uout;
  assign sleep_active       = s_q.sleep;
  assign event_pause        = s_q.ev_pause;
  assign locking            = s_q.locking;

endmodule

// ==== rtl/mcc_defs.svh ====
`ifndef MCC_DEFS_SVH
`define MCC_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define MCC_OFF_CTRL      8'h00
`define MCC_OFF_IN_DLY    8'h04
`define MCC_OFF_AUTO_DLY  8'h08
`define MCC_OFF_STATUS    8'h0C
`define MCC_OFF_CASE0     8'h10
`define MCC_OFF_CASE3     8'h1C

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MCC_CTRL_MODE_LSB 0
`define MCC_CTRL_CFB      2
`define MCC_CTRL_ANTI     3
`define MCC_CTRL_POL_LSB  4
`define MCC_CASE_P0_LSB   0
`define MCC_CASE_P1_LSB   2
`define MCC_CASE_SLEEP    4
`define MCC_CASE_USED     5

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define MCC_CLK_PERIOD_NS 4
`define MCC_MS_NS         1000000
`define MCC_IN_DELAY_MS   16'h000C
`define MCC_AUTO_DELAY_MS 16'h01F4
`define MCC_CFB_WAIT_MS   16'h000A
`define MCC_BLINK_HALF_MS 10'h0FA
`define MCC_RESP_OKAY     2'h0
`define MCC_RESP_SLVERR   2'h2

`endif

// ==== rtl/mcc_pkg.sv ====
package mcc_pkg;

  // cut-off behaviour of one path in a monitoring case
  typedef enum logic [1:0] {
    MCC_BEH_OFF,
    MCC_BEH_FIELD,
    MCC_BEH_ON_UNSAFE,
    MCC_BEH_ON_SAFE
  } mcc_beh_t;

  // restart behaviour of the safe output pair
  typedef enum logic [1:0] {
    MCC_RS_IMMEDIATE,
    MCC_RS_INTERLOCK,
    MCC_RS_AUTO
  } mcc_restart_t;

  typedef struct packed {
    // bus slave
    logic             awready;
    logic             wready;
    logic             aw_have;
    logic             w_have;
    logic [7:0]       aw_addr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    // configuration
    logic [1:0]       rs_mode;
    logic             cfb_en;
    logic             anti_en;
    logic [3:0]       pol;
    logic [15:0]      in_dly_ms;
    logic [15:0]      auto_dly_ms;
    logic [3:0][5:0]  case_cfg;
    // core
    logic [17:0]      ms_cnt;
    logic [3:0]       btn_prev;
    logic [1:0]       cand;
    logic [15:0]      dly_cnt;
    logic [1:0]       act_case;
    logic             case_ok;
    logic             anti_err;
    logic             latch;
    logic [15:0]      auto_cnt;
    logic             on;
    logic             cfb_wait;
    logic [15:0]      cfb_cnt;
    logic             cfb_fault;
    logic             locking;
    logic             sleep_btn;
    logic             sleep;
    logic             ev_pause;
    logic [9:0]       blink_cnt;
    logic             blink;
    logic [3:0]       uout;
  } mcc_state_t;

endpackage

// ==== rtl/mcc_path_if.sv ====
`timescale 1ns/100ps

// one cut-off path: behaviour and field in, output demands back
interface mcc_path_if;
  mcc_pkg::mcc_beh_t beh;
  logic              field_obj;
  logic              safe_on;
  logic              nonsafe_on;

  modport path (input beh, input field_obj, output safe_on, output nonsafe_on);
  modport ctl  (output beh, output field_obj, input safe_on, input nonsafe_on);
endinterface

// ==== rtl/mcc_cutoff_path.sv ====
`timescale 1ns/100ps

module mcc_cutoff_path (
  // path carrier
  mcc_path_if.path p
);

  // behaviour decode; unknown codes fall back to off for safety
  always_comb begin
    case (p.beh)
      mcc_pkg::MCC_BEH_FIELD: begin
        p.safe_on    = !p.field_obj;
        p.nonsafe_on = !p.field_obj;
      end
      mcc_pkg::MCC_BEH_ON_UNSAFE: begin
        p.safe_on    = 1'b0;
        p.nonsafe_on = 1'b1;
      end
      mcc_pkg::MCC_BEH_ON_SAFE: begin
        p.safe_on    = 1'b1;
        p.nonsafe_on = 1'b1;
      end
      default: begin
        p.safe_on    = 1'b0;
        p.nonsafe_on = 1'b0;
      end
    endcase
  end

endmodule

// ==== dv/mcc_checker.sv ====
`timescale 1ns/100ps

// ----------------------------------------------------------------
// pin level checks
// ----------------------------------------------------------------
module mcc_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // causes
  input wire logic dev_err,
  input wire logic btn_restart,
  input wire logic btn_sleep,
  input wire logic btn_pause,
  // effects
  input wire logic safe_output_pair_a,
  input wire logic safe_output_pair_b,
  input wire logic sleep_active,
  input wire logic event_pause,
  input wire logic locking
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // error held past the one-cycle register lag
  sequence s_err;
    dev_err [*4];
  endsequence
  // restart press with no error pending
  sequence s_rst;
    $rose(btn_restart) ##0 !dev_err [*4];
  endsequence

  property p_pair_eq;
    safe_output_pair_a == safe_output_pair_b;
  endproperty
  property p_err_lock;
    s_err |-> locking;
  endproperty
  property p_lock_off;
    locking [*3] |-> !safe_output_pair_a;
  endproperty
  property p_on_cause;
    $rose(safe_output_pair_a) |-> !$past(locking) && !locking && !sleep_active;
  endproperty
  property p_sleep_off;
    sleep_active [*3] |-> !safe_output_pair_a;
  endproperty
  property p_rst_clr;
    s_rst |-> !locking;
  endproperty
  property p_sleep_btn;
    $rose(btn_sleep) |-> ##[1:3] sleep_active;
  endproperty
  property p_pause_btn;
    $rose(btn_pause) |-> ##[1:3] $changed(event_pause);
  endproperty

  a_pair_eq: assert property (p_pair_eq) else $error("pair halves differ");
  a_err_lock: assert property (p_err_lock) else $error("no lock on error");
  a_lock_off: assert property (p_lock_off) else $error("pair on while locked");
  a_on_cause: assert property (p_on_cause) else $error("pair on from lock");
  a_sleep_off: assert property (p_sleep_off) else $error("pair on in sleep");
  a_rst_clr: assert property (p_rst_clr) else $error("restart kept lock");
  a_sleep_btn: assert property (p_sleep_btn) else $error("sleep press lost");
  a_pause_btn: assert property (p_pause_btn) else $error("pause press lost");
endmodule

bind mcc_top mcc_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .dev_err(dev_err), .btn_restart(btn_restart),
  .btn_sleep(btn_sleep), .btn_pause(btn_pause), .safe_output_pair_a(safe_output_pair_a),
  .safe_output_pair_b(safe_output_pair_b), .sleep_active(sleep_active),
  .event_pause(event_pause), .locking(locking)
);

// ==== dv/mcc_partner.sv ====
`timescale 1ns/100ps

// ----------------------------------------------------------------
// controller and contactor pair at the far side
// ----------------------------------------------------------------
module mcc_partner (
  // clock
  input  wire logic       aclk,
  // faults ordered by the bench
  input  wire logic       anti_break,
  input  wire logic       fb_break,
  // controller channel a and the pair
  input  wire logic [1:0] ctl_a,
  input  wire logic       sa,
  // lines back into the block
  output logic      [1:0] ctl_b,
  output logic            contactor_fb
);
  logic [2:0] coil_q = 3'h0;

  // channel b flips in the same instant, so no settling time is needed
  assign ctl_b = anti_break ? ctl_a : ~ctl_a;
  // contactor drops some cycles after the pair; a welded one never reports
  always_ff @(posedge aclk) begin
    coil_q <= {coil_q[1:0], sa};
  end
  assign contactor_fb = !fb_break && !(|coil_q);
endmodule

// ==== dv/mcc_top_tb.sv ====
`timescale 1ns/100ps

module mcc_top_tb;
  localparam int CPM = 10;
  localparam logic [3:0][3:0] CFG = {4'h3, 4'hA, 4'h5, 4'h0};

  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [1:0]  ctl_a = 2'h0;
  logic [1:0]  field_obj = 2'h0;
  logic        dev_err = 1'b0;
  logic [3:0]  btn = 4'h0;
  logic        anti_break = 1'b0;
  logic        fb_break = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, fb, sa, sb, slp, evp, lck, u;
  logic [1:0]  bresp, rresp, ctl_b;
  logic [31:0] rdata;
  logic [3:0]  uout;
  logic [31:0] rnd = 32'h8C4705C4;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          tcnt = 0;
  int          k;

  mcc_top #(.CYC_PER_MS(CPM)) uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .ctl_a(ctl_a), .ctl_b(ctl_b),
    .field_obj(field_obj), .contactor_fb(fb), .dev_err(dev_err),
    .btn_reset(btn[0]), .btn_sleep(btn[1]), .btn_restart(btn[2]), .btn_pause(btn[3]),
    .safe_output_pair_a(sa), .safe_output_pair_b(sb), .uout(uout),
    .sleep_active(slp), .event_pause(evp), .locking(lck)
  );

  mcc_partner u_prt (
    .aclk(aclk), .anti_break(anti_break), .fb_break(fb_break), .ctl_a(ctl_a),
    .sa(sa), .ctl_b(ctl_b), .contactor_fb(fb)
  );

  // ----------------------------------------------------------------
  // clock, timeout, helpers
  // ----------------------------------------------------------------
  always #2 aclk = ~aclk;

  // a hang counts as a mismatch
  always @(posedge aclk) begin
    tcnt <= tcnt + 1;
    if (tcnt == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // expected on-state of a path; s marks a safety output
  function automatic logic path_on(input logic [1:0] b, input logic o, input logic s);
    return (b == mcc_pkg::MCC_BEH_ON_SAFE) || (b == mcc_pkg::MCC_BEH_FIELD && !o)
      || (!s && b == mcc_pkg::MCC_BEH_ON_UNSAFE);
  endfunction

  task automatic complete_run();
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // bus write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    @(posedge aclk);
    aw = 1'b0;
    w = 1'b0;
    awaddr <= 32'(a);
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask

  // bus read, masked compare of the word
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                     input logic [1:0] er);
    @(posedge aclk);
    araddr <= 32'(a);
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata & m, e);
    chk(32'(rresp), 32'(er));
  endtask

  task automatic press(input int i);
    @(posedge aclk);
    btn[i] <= 1'b1;
    cyc(3);
    btn[i] <= 1'b0;
    cyc(4);
  endtask

  // select a case and wait out the input delay plus tick jitter
  task automatic sel(input logic [1:0] n);
    @(posedge aclk);
    ctl_a <= n;
    cyc(5 * CPM);
    rdc(8'h0C, 32'({1'b1, n}), 32'h7, 2'h0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'({sa, sb, uout, lck, slp, evp}), 32'h0);
    rdc(8'h00, 32'h0, 32'hFFFFFFFF, 2'h0);
    rdc(8'h04, 32'hC, 32'hFFFFFFFF, 2'h0);
    rdc(8'h08, 32'h1F4, 32'hFFFFFFFF, 2'h0);
    rdc(8'h40, 32'h0, 32'hFFFFFFFF, 2'h2);
    wr(8'h40, 32'h1, 2'h2);
    wr(8'h04, 32'h2, 2'h0);
    wr(8'h08, 32'h3, 2'h0);
    sel(2'h0);
    chk(32'(sa), 32'h0);
    for (int i = 3; i >= 0; i--) begin
      wr(8'(8'h10 + 4 * i), (i == 0) ? 32'h30 : 32'(6'h20 | CFG[i]), 2'h0);
    end
    // buttons in a plain case, then sleep entered by case selection
    sel(2'h1);
    press(0);
    chk(32'(slp), 32'h0);
    press(1);
    chk(32'(slp), 32'h1);
    press(0);
    press(3);
    chk(32'({slp, evp}), 32'h1);
    press(3);
    chk(32'(evp), 32'h0);
    sel(2'h0);
    chk(32'({slp, sa}), 32'h2);
    sel(2'h1);
    press(0);
    // random field states against every cut-off behaviour
    for (int n = 1; n < 4; n++) begin
      sel(2'(n));
      repeat (12) begin
        rnd = lfsr(rnd);
        field_obj <= rnd[1:0];
        cyc(4);
        chk(32'({sa, uout[0]}), 32'({path_on(CFG[n][1:0], rnd[0], 1'b1),
            path_on(CFG[n][3:2], rnd[1], 1'b0)}));
      end
    end
    field_obj <= 2'h0;
    ctl_a <= 2'h1;
    cyc(3);
    rdc(8'h0C, 32'h3, 32'h3, 2'h0);
    sel(2'h1);
    wr(8'h00, 32'h90, 2'h0);
    cyc(3);
    chk(32'({uout[3], uout[0]}), 32'h2);
    wr(8'h00, 32'h0, 2'h0);
    field_obj <= 2'h3;
    cyc(4);
    chk(32'(uout[1]), 32'h1);
    field_obj <= 2'h0;
    cyc(4);
    chk(32'(uout[1]), 32'h0);
    // interlocked: stays off, flashes, reset button releases
    wr(8'h00, 32'h1, 2'h0);
    field_obj <= 2'h1;
    cyc(4);
    field_obj <= 2'h0;
    cyc(20);
    chk(32'(sa), 32'h0);
    u = uout[2];
    k = 0;
    while (uout[2] === u && k < 3000) begin
      cyc(1);
      k++;
    end
    chk(32'(uout[2] !== u), 32'h1);
    press(0);
    chk(32'(sa), 32'h1);
    // automatic restart after three ticks of clear field
    wr(8'h00, 32'h2, 2'h0);
    field_obj <= 2'h1;
    cyc(4);
    field_obj <= 2'h0;
    cyc(15);
    chk(32'(sa), 32'h0);
    cyc(30);
    chk(32'(sa), 32'h1);
    // feedback check, good contactor then welded one
    wr(8'h00, 32'h4, 2'h0);
    field_obj <= 2'h1;
    cyc(12 * CPM);
    chk(32'(lck), 32'h0);
    field_obj <= 2'h0;
    cyc(5);
    chk(32'(sa), 32'h1);
    fb_break <= 1'b1;
    field_obj <= 2'h1;
    cyc(12 * CPM);
    field_obj <= 2'h0;
    cyc(10);
    chk(32'({lck, sa}), 32'h2);
    fb_break <= 1'b0;
    press(2);
    chk(32'(lck), 32'h0);
    wr(8'h00, 32'h0, 2'h0);
    // device error locks until restart
    dev_err <= 1'b1;
    cyc(6);
    dev_err <= 1'b0;
    cyc(5);
    chk(32'({lck, sa}), 32'h2);
    press(2);
    sel(2'h1);
    // antivalence broken by the controller
    wr(8'h00, 32'h8, 2'h0);
    cyc(5);
    chk(32'(sa), 32'h1);
    anti_break <= 1'b1;
    cyc(4);
    chk(32'({uout[3], sa}), 32'h2);
    rdc(8'h0C, 32'h40, 32'h40, 2'h0);
    anti_break <= 1'b0;
    cyc(10);
    chk(32'(sa), 32'h1);
    complete_run();
  end
endmodule
